// File: src/marker_freeze_pkg.sv
// Package with register map, field layouts and codes of the marker and freeze capture control.
package marker_freeze_pkg;

   // Register offsets on the parameter port.
   localparam logic [7:0] reg_event_trigger       = 8'h00;
   localparam logic [7:0] reg_reference_marker    = 8'h04;
   localparam logic [7:0] reg_feedback_marker     = 8'h08;
   localparam logic [7:0] reg_reference_source    = 8'h0c;
   localparam logic [7:0] reg_feedback_source     = 8'h10;
   localparam logic [7:0] reg_reference_mark_en   = 8'h14;
   localparam logic [7:0] reg_feedback_mark_en    = 8'h18;
   localparam logic [7:0] reg_reference_freeze_en = 8'h1c;
   localparam logic [7:0] reg_feedback_freeze_en  = 8'h20;
   localparam logic [7:0] reg_runtime_error       = 8'h24;
   localparam logic [7:0] reg_freeze_flags        = 8'h28;
   localparam logic [7:0] reg_marker_position     = 8'h2c;
   localparam logic [7:0] reg_freeze_route        = 8'h30;
   localparam logic [7:0] reg_irq_status          = 8'h34;
   localparam logic [7:0] reg_irq_mask            = 8'h38;

   // Reset values.
   localparam logic [7:0]  source_reset   = 8'h05;
   localparam logic [31:0] error_reset    = 32'h0000_0000;

   // Event trigger codes.
   localparam logic [15:0] trig_none  = 16'h0000;
   localparam logic [15:0] trig_base  = 16'h0001;
   localparam logic [15:0] trig_last  = 16'h0004;

   // Source codes.
   localparam logic [7:0] src_drive_first   = 8'h00;
   localparam logic [7:0] src_slot1_first   = 8'h01;
   localparam logic [7:0] src_slot3_first   = 8'h03;
   localparam logic [7:0] src_user_program  = 8'h04;
   localparam logic [7:0] src_unconfigured  = 8'h05;
   localparam logic [7:0] src_drive_second  = 8'h06;
   localparam logic [7:0] src_slot3_second  = 8'h09;
   localparam logic [7:0] src_slot4_first   = 8'h0a;
   localparam logic [7:0] src_slot4_second  = 8'h0b;

   // Runtime error codes.
   localparam logic [31:0] err_none_or_setup   = 32'h0000_0000;
   localparam logic [31:0] err_cam_too_small   = 32'h0000_0001;
   localparam logic [31:0] err_cam_overrun     = 32'h0000_0002;
   localparam logic [31:0] err_cam_size_zero   = 32'h0000_0003;
   localparam logic [31:0] err_cam_abs_reset   = 32'h0000_0004;

   // Interrupt status bit positions.
   localparam int irq_ref_marker  = 0;
   localparam int irq_fb_marker   = 1;
   localparam int irq_ref_freeze  = 2;
   localparam int irq_fb_freeze   = 3;
   localparam int irq_trip        = 4;
   localparam int irq_width       = 5;

   // Decoded source: which interface and which of five places (0 drive, 1..4 slots).
   typedef struct packed {
      logic       valid;
      logic       second;
      logic [2:0] place;
   } source_route_t;

   // Raw inputs from the five places, first and second interface each.
   typedef struct packed {
      logic [4:0] marker_first;
      logic [4:0] marker_second;
      logic [4:0] freeze_first;
      logic [4:0] freeze_second;
   } encoder_pins_t;

   // Source value to route, shared by selector and freeze logic.
   function automatic source_route_t decode_source(input logic [7:0] sel);
      source_route_t r;
      r = '0;
      if (sel == src_drive_first) begin
         r = '{1'b1, 1'b0, 3'd0};
      end else if (sel >= src_slot1_first && sel <= src_slot3_first) begin
         r = '{1'b1, 1'b0, sel[2:0]};
      end else if (sel == src_slot4_first) begin
         r = '{1'b1, 1'b0, 3'd4};
      end else if (sel >= src_drive_second && sel <= src_slot3_second) begin
         r = '{1'b1, 1'b1, 3'(sel - src_drive_second)};
      end else if (sel == src_slot4_second) begin
         r = '{1'b1, 1'b1, 3'd4};
      end
      return r;
   endfunction

endpackage

// File: src/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pin inputs.
module pin_sync
   import marker_freeze_pkg::*;
#(
   parameter int width = 20
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [width-1:0] pin_in,
   output logic      [width-1:0] level,
   output logic      [width-1:0] rise
);
   typedef struct packed {
      logic [width-1:0] s1;
      logic [width-1:0] s2;
      logic [width-1:0] s3;
      logic [width-1:0] lvl;
      logic [width-1:0] edge_q;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   // A change counts only once stages two and three agree; stage one feeds stage two alone.
   always_comb begin
      next_state        = state;
      next_state.s1     = pin_in;
      next_state.s2     = state.s1;
      next_state.s3     = state.s2;
      next_state.lvl    = state.lvl;
      for (int i = 0; i < width; i++) begin
         if (state.s2[i] == state.s3[i]) begin
            next_state.lvl[i] = state.s3[i];
         end
      end
      next_state.edge_q = next_state.lvl & ~state.lvl;
   end

   // Registers the whole state.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign level = state.lvl;
   assign rise  = state.edge_q;
endmodule // pin_sync

// File: src/event_trigger.sv
// Event trigger decoder that turns a trigger write into one task start pulse.
module event_trigger
   import marker_freeze_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        write_stb,
   input  wire logic [15:0] value,
   output logic      [15:0] last_value,
   output logic      [3:0]  task_start
);
   typedef struct packed {
      logic [15:0] last;
      logic [3:0]  start;
   } trig_state_t;

   trig_state_t state;
   trig_state_t next_state;

   // Value 0 starts nothing, 1 the base task, 2..4 the numbered tasks; others are ignored.
   always_comb begin
      next_state       = state;
      next_state.start = 4'h0;
      if (write_stb) begin
         next_state.last = value;
         if (value >= trig_base && value <= trig_last) begin
            next_state.start = 4'(4'h1 << (value - trig_base));
         end
      end
   end

   // Registers the whole state.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= '{trig_none, 4'h0};
      end else begin
         state <= next_state;
      end
   end

   assign last_value = state.last;
   assign task_start = state.start;
endmodule // event_trigger

// File: src/marker_freeze_control.sv
// Marker flags, freeze enables, source routing and runtime error register of the position option.
//
// Design decisions made here: the placing of the registers and strobed register access.
module marker_freeze_control
   import marker_freeze_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rst_n,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_write,
   input  wire logic          reg_read,
   output logic      [31:0]   reg_rdata,
   input  wire encoder_pins_t enc_pins,
   input  wire logic [31:0]   reference_position,
   input  wire logic          trip_81,
   input  wire logic [31:0]   trip_error_code,
   output logic      [3:0]    task_start,
   output logic               first_freeze_position_source,
   output logic               second_freeze_position_source,
   output logic               irq
);
   typedef struct packed {
      logic                 ref_marker;
      logic                 fb_marker;
      logic [7:0]           ref_source;
      logic [7:0]           fb_source;
      logic                 ref_mark_en;
      logic                 fb_mark_en;
      logic                 ref_freeze_en;
      logic                 fb_freeze_en;
      logic                 ref_freeze;
      logic                 fb_freeze;
      logic [31:0]          runtime_error;
      logic [31:0]          marker_position;
      logic                 route_first;
      logic                 route_second;
      logic [irq_width-1:0] irq_status;
      logic [irq_width-1:0] irq_mask;
      logic                 trip_prev;
      logic [31:0]          rdata;
   } ctrl_state_t;

   ctrl_state_t   state;
   ctrl_state_t   next_state;
   encoder_pins_t pin_rise;
   logic [15:0]   trig_last;
   source_route_t ref_route;
   source_route_t fb_route;
   logic          ref_marker_evt;
   logic          fb_marker_evt;
   logic          ref_freeze_evt;
   logic          fb_freeze_evt;
   logic          trip_evt;
   logic [irq_width-1:0] irq_events;

   // Pins arrive from other boards, so they all pass the agreement synchroniser.
   pin_sync #(
      .width ($bits(encoder_pins_t))
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin_in  (enc_pins),
      .level   (),
      .rise    (pin_rise)
   );

   // Trigger writes decode into one start pulse per task.
   event_trigger u_event_trigger (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .write_stb  (reg_write && reg_addr == reg_event_trigger),
      .value      (reg_wdata[15:0]),
      .last_value (trig_last),
      .task_start (task_start)
   );

   // Picks the marker or freeze edge of the place and interface a channel is routed to.
   function automatic logic pick(input source_route_t r, input logic [4:0] first, input logic [4:0] second);
      logic hit;
      hit = 1'b0;
      if (r.valid) begin
         hit = r.second ? second[r.place] : first[r.place];
      end
      return hit;
   endfunction

   // Source decode; user program and unconfigured codes decode to no route, so no pin reaches them.
   always_comb begin
      ref_route      = decode_source(state.ref_source);
      fb_route       = decode_source(state.fb_source);
      ref_marker_evt = pick(ref_route, pin_rise.marker_first, pin_rise.marker_second);
      fb_marker_evt  = pick(fb_route, pin_rise.marker_first, pin_rise.marker_second);
      ref_freeze_evt = pick(ref_route, pin_rise.freeze_first, pin_rise.freeze_second);
      fb_freeze_evt  = pick(fb_route, pin_rise.freeze_first, pin_rise.freeze_second);
   end

   // Trip is a level from the same clock; only its rising edge loads the error register.
   assign trip_evt = trip_81 && !state.trip_prev;

   // Main next-state logic: software writes first, then hardware sets so that sets win over clears.
   always_comb begin
      next_state       = state;
      next_state.rdata = 32'h0000_0000;
      irq_events       = '0;
      next_state.trip_prev = trip_81;

      // Register writes.
      if (reg_write) begin
         case (reg_addr)
            reg_reference_marker: begin
               if (!reg_wdata[0]) begin
                  next_state.ref_marker = 1'b0;
               end
            end
            reg_feedback_marker: begin
               if (!reg_wdata[0]) begin
                  next_state.fb_marker = 1'b0;
               end
            end
            reg_reference_source:    next_state.ref_source    = reg_wdata[7:0];
            reg_feedback_source:     next_state.fb_source     = reg_wdata[7:0];
            reg_reference_mark_en:   next_state.ref_mark_en   = reg_wdata[0];
            reg_feedback_mark_en:    next_state.fb_mark_en    = reg_wdata[0];
            reg_reference_freeze_en: next_state.ref_freeze_en = reg_wdata[0];
            reg_feedback_freeze_en:  next_state.fb_freeze_en  = reg_wdata[0];
            reg_freeze_flags: begin
               // Freeze flags re-arm by writing zero to their bit; writing one is ignored.
               if (!reg_wdata[0]) begin
                  next_state.ref_freeze = 1'b0;
               end
               if (!reg_wdata[1]) begin
                  next_state.fb_freeze = 1'b0;
               end
            end
            reg_irq_status: next_state.irq_status = state.irq_status & ~reg_wdata[irq_width-1:0];
            reg_irq_mask:   next_state.irq_mask   = reg_wdata[irq_width-1:0];
            default: begin
            end
         endcase
      end

      // Marker capture; a set flag swallows further pulses, so position holds the first one.
      if (ref_marker_evt && state.ref_mark_en && !state.ref_marker) begin
         next_state.ref_marker      = 1'b1;
         next_state.marker_position = reference_position;
         irq_events[irq_ref_marker] = 1'b1;
      end
      if (fb_marker_evt && state.fb_mark_en && !state.fb_marker) begin
         next_state.fb_marker       = 1'b1;
         irq_events[irq_fb_marker]  = 1'b1;
      end

      // Freeze capture only while the flag is zero and enabled.
      if (ref_freeze_evt && state.ref_freeze_en && !state.ref_freeze) begin
         next_state.ref_freeze      = 1'b1;
         irq_events[irq_ref_freeze] = 1'b1;
      end
      if (fb_freeze_evt && state.fb_freeze_en && !state.fb_freeze) begin
         next_state.fb_freeze       = 1'b1;
         irq_events[irq_fb_freeze]  = 1'b1;
      end

      // Error code is stored as given; codes 0 to 4 are defined, others pass through unchanged.
      if (trip_evt) begin
         next_state.runtime_error = trip_error_code;
         irq_events[irq_trip]     = 1'b1;
      end

      // Freeze position routing follows the selected interfaces; it is sticky so a later
      // user-program selection does not undo a routing software may rely on.
      if ((ref_route.valid && !ref_route.second) || (fb_route.valid && !fb_route.second)) begin
         next_state.route_first = 1'b1;
      end
      if ((ref_route.valid && ref_route.second) || (fb_route.valid && fb_route.second)) begin
         next_state.route_second = 1'b1;
      end

      next_state.irq_status = next_state.irq_status | irq_events;

      // Register reads; data appear the cycle after the strobe.
      if (reg_read) begin
         case (reg_addr)
            reg_event_trigger:       next_state.rdata = {16'h0000, trig_last};
            reg_reference_marker:    next_state.rdata = {31'h0, state.ref_marker};
            reg_feedback_marker:     next_state.rdata = {31'h0, state.fb_marker};
            reg_reference_source:    next_state.rdata = {24'h0, state.ref_source};
            reg_feedback_source:     next_state.rdata = {24'h0, state.fb_source};
            reg_reference_mark_en:   next_state.rdata = {31'h0, state.ref_mark_en};
            reg_feedback_mark_en:    next_state.rdata = {31'h0, state.fb_mark_en};
            reg_reference_freeze_en: next_state.rdata = {31'h0, state.ref_freeze_en};
            reg_feedback_freeze_en:  next_state.rdata = {31'h0, state.fb_freeze_en};
            reg_runtime_error:       next_state.rdata = state.runtime_error;
            reg_freeze_flags:        next_state.rdata = {30'h0, state.fb_freeze, state.ref_freeze};
            reg_marker_position:     next_state.rdata = state.marker_position;
            reg_freeze_route:        next_state.rdata = {30'h0, state.route_second, state.route_first};
            reg_irq_status:          next_state.rdata = {27'h0, state.irq_status};
            reg_irq_mask:            next_state.rdata = {27'h0, state.irq_mask};
            default:                 next_state.rdata = 32'h0000_0000;
         endcase
      end
   end

   // Registers the whole state; sources reset to unconfigured so nothing is routed.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state               <= '0;
         state.ref_source    <= source_reset;
         state.fb_source     <= source_reset;
         state.runtime_error <= error_reset;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata                     = state.rdata;
   assign first_freeze_position_source  = state.route_first;
   assign second_freeze_position_source = state.route_second;
   assign irq                           = |(state.irq_status & state.irq_mask);
endmodule // marker_freeze_control

// File: testbench/marker_freeze_control_checker.sv
// Checker with the port-level timing properties of the marker and freeze capture control.
module marker_freeze_checker
   import marker_freeze_pkg::*;
(
   input wire logic          clk_sys,
   input wire logic          rst_n,
   input wire logic [7:0]    reg_addr,
   input wire logic [31:0]   reg_wdata,
   input wire logic          reg_write,
   input wire logic          reg_read,
   input wire logic [31:0]   reg_rdata,
   input wire encoder_pins_t enc_pins,
   input wire logic [31:0]   reference_position,
   input wire logic          trip_81,
   input wire logic [31:0]   trip_error_code,
   input wire logic [3:0]    task_start,
   input wire logic          first_freeze_position_source,
   input wire logic          second_freeze_position_source,
   input wire logic          irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Trigger writes: a valid code starts exactly its own task, anything else starts nothing.
   trig_start_a:
   assert property (reg_write && reg_addr == reg_event_trigger && reg_wdata[15:0] >= trig_base &&
      reg_wdata[15:0] <= trig_last |=> task_start == (4'h1 << ($past(reg_wdata[1:0]) - 2'h1)))
      else $error("wrong task start after trigger write");
   trig_none_a:
   assert property (reg_write && reg_addr == reg_event_trigger &&
      (reg_wdata[15:0] == trig_none || reg_wdata[15:0] > trig_last) |=> task_start == 4'h0)
      else $error("task started by a code that starts none");
   task_cause_a:
   assert property (task_start != 4'h0 |-> $past(reg_write && reg_addr == reg_event_trigger))
      else $error("task start without trigger write");
   // Read data stand only in the cycle after a read strobe.
   rdata_idle_a:
   assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside the answer cycle");
   trip_load_a:
   assert property ($rose(trip_81) ##2 (reg_read && reg_addr == reg_runtime_error)
      |=> reg_rdata == $past(trip_error_code, 3))
      else $error("error identifier not loaded at trip");
   // Routing is sticky once set, so it may only ever grow.
   route_sticky_a:
   assert property ({first_freeze_position_source, second_freeze_position_source} != 2'b00 |=>
      ({first_freeze_position_source, second_freeze_position_source} &
       $past({first_freeze_position_source, second_freeze_position_source})) ==
       $past({first_freeze_position_source, second_freeze_position_source}))
      else $error("freeze routing dropped");
   route_first_a:
   assert property (reg_write && (reg_addr == reg_reference_source || reg_addr == reg_feedback_source) &&
      (reg_wdata[7:0] <= src_slot3_first || reg_wdata[7:0] == src_slot4_first)
      |-> ##[1:3] first_freeze_position_source)
      else $error("first freeze not routed");
   route_second_a:
   assert property (reg_write && (reg_addr == reg_reference_source || reg_addr == reg_feedback_source) &&
      ((reg_wdata[7:0] >= src_drive_second && reg_wdata[7:0] <= src_slot3_second) ||
       reg_wdata[7:0] == src_slot4_second) |-> ##[1:3] second_freeze_position_source)
      else $error("second freeze not routed");
   // Main scenarios reached.
   cover property (task_start == 4'h8);
   cover property ($rose(trip_81));
   cover property ($rose(second_freeze_position_source));
   cover property ($rose(irq));
endmodule // marker_freeze_checker

// File: testbench/drive_side_model.sv
// Drive-side model: marker and freeze pins, live reference position and trip source.
module drive_side_model
   import marker_freeze_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          pulse_go,
   input  wire encoder_pins_t pulse_sel,
   input  wire logic          trip_go,
   input  wire logic [31:0]   trip_code,
   output encoder_pins_t      enc_pins,
   output logic      [31:0]   reference_position,
   output logic               trip_81,
   output logic      [31:0]   trip_error_code
);
   int pulse_cnt = 0;
   int trip_cnt  = 0;
   // Outputs start quiet; the error code line shows junk outside a trip.
   initial begin
      enc_pins = '0;
      reference_position = 32'h1234_0000;
      trip_81 = 1'b0;
      trip_error_code = 32'hdead_beef;
   end
   // Pins stay high eight cycles so the three-cycle filter always passes them.
   // Position holds during a pulse, so the captured value is unambiguous.
   always @(posedge clk_sys) begin
      if (pulse_go && pulse_cnt == 0) begin
         enc_pins <= pulse_sel;
         pulse_cnt <= 8;
      end else if (pulse_cnt > 0) begin
         pulse_cnt <= pulse_cnt - 1;
         if (pulse_cnt == 1) enc_pins <= '0;
      end else begin
         reference_position <= reference_position + 32'h3;
      end
      if (trip_go && trip_cnt == 0) begin
         trip_81 <= 1'b1;
         trip_error_code <= trip_code;
         trip_cnt <= 4;
      end else if (trip_cnt > 0) begin
         trip_cnt <= trip_cnt - 1;
         if (trip_cnt == 1) trip_81 <= 1'b0;
         if (trip_cnt == 1) trip_error_code <= ~trip_error_code;
      end
   end
endmodule // drive_side_model

// File: testbench/test_encoder_marker_freeze_capture_control.sv
// Self-checking bench for the marker and freeze capture control against an integer reference model.
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module test_encoder_marker_freeze_capture_control
   import marker_freeze_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          clk_sys = 0, rst_n = 0, reg_write = 0, reg_read = 0, pulse_go = 0, trip_go = 0;
   logic [7:0]    reg_addr = 8'h00;
   logic [31:0]   reg_wdata = 32'h0, trip_code = 32'h0, d, pos_hold;
   encoder_pins_t pulse_sel = '0, p;
   wire logic [31:0] reg_rdata, reference_position, trip_error_code;
   wire encoder_pins_t enc_pins;
   wire logic [3:0]  task_start;
   wire logic        first_src, second_src, irq, trip_81;
   int bad_count = 0, check_count = 0, cyc = 0, v, pl, ch;
   int src[2] = '{5, 5}, flag[2] = '{0, 0}, fz[2] = '{0, 0}, men[2] = '{0, 0}, fen[2] = '{0, 0};
   int rt1 = 0, rt2 = 0, pos_exp = 0, newpos;
   always #2 clk_sys = ~clk_sys;
   marker_freeze_control u_marker_freeze_control (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .enc_pins(enc_pins), .reference_position(reference_position), .trip_81(trip_81),
      .trip_error_code(trip_error_code), .task_start(task_start), .first_freeze_position_source(first_src),
      .second_freeze_position_source(second_src), .irq(irq));
   drive_side_model u_drive_side_model (.clk_sys(clk_sys), .pulse_go(pulse_go), .pulse_sel(pulse_sel),
      .trip_go(trip_go), .trip_code(trip_code), .enc_pins(enc_pins), .reference_position(reference_position),
      .trip_81(trip_81), .trip_error_code(trip_error_code));
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // A hang counts as a mismatch and still reaches the report.
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 r = reg_rdata;
   endtask
   function automatic int place_of(input int s);
      if (s == 0 || s == 6) return 0;
      if ((s >= 1 && s <= 3) || (s >= 7 && s <= 9)) return s % 6;
      if (s == 10 || s == 11) return 4;
      return -1;
   endfunction
   // Pulse the pins, then let the model record what a qualifying pulse must set.
   task automatic pulse(input encoder_pins_t q);
      int k;
      logic sec;
      @(posedge clk_sys);
      pulse_go <= 1'b1;
      pulse_sel <= q;
      @(posedge clk_sys);
      pulse_go <= 1'b0;
      #1 pos_hold = reference_position;
      repeat (16) @(posedge clk_sys);
      for (int c = 0; c < 2; c++) begin
         k = place_of(src[c]);
         sec = src[c] >= 6 && src[c] != 10;
         if (k >= 0 && men[c] != 0 && flag[c] == 0 && (sec ? q.marker_second[k] : q.marker_first[k])) begin
            flag[c] = 1;
            if (c == 0) pos_exp = pos_hold;
            if (c == 0) newpos = 1;
         end
         if (k >= 0 && fen[c] != 0 && (sec ? q.freeze_second[k] : q.freeze_first[k])) fz[c] = 1;
      end
   endtask
   task automatic check_flags;
      rd(reg_reference_marker, d); `CHK(d, flag[0])
      rd(reg_feedback_marker, d); `CHK(d, flag[1])
      rd(reg_freeze_flags, d); `CHK(d, fz[0] + 2 * fz[1])
   endtask
   initial begin
      void'($urandom(32'h6978dd7c));
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(reg_reference_source, d); `CHK(d, 5)
      rd(reg_runtime_error, d); `CHK(d, 0)
      // Every trigger code, plus a random out-of-range one.
      for (int i = 0; i < 6; i++) begin
         v = (i < 5) ? i : 5 + $urandom % 65531;
         wr(reg_event_trigger, v);
         #1 `CHK(task_start, (v >= 1 && v <= 4) ? (1 << (v - 1)) : 0)
      end
      // Pulses with enables off, and a write of one, must leave every flag clear.
      wr(reg_reference_source, 0);
      src[0] = 0;
      rt1 = 1;
      pulse('1);
      wr(reg_reference_marker, 1);
      wr(reg_freeze_flags, 3);
      check_flags();
      for (int a = 0; a < 4; a++) wr(reg_reference_mark_en + 8'(4 * a), 1);
      men = '{1, 1};
      fen = '{1, 1};
      // Walk all source codes, alternating channels; codes without a source get every pin pulsed.
      for (int s = 0; s < 12; s++) begin
         ch = s % 2;
         wr(ch ? reg_feedback_source : reg_reference_source, s);
         src[ch] = s;
         pl = place_of(s);
         p = '0;
         if (pl < 0) p = '1;
         else if (s >= 6 && s != 10) {p.marker_second[pl], p.freeze_second[pl]} = 2'b11;
         else {p.marker_first[pl], p.freeze_first[pl]} = 2'b11;
         if (pl >= 0 && (s >= 6 && s != 10)) rt2 = 1;
         else if (pl >= 0) rt1 = 1;
         newpos = 0;
         pulse(p);
         pulse(p);
         check_flags();
         if (newpos != 0) rd(reg_marker_position, d);
         if (newpos != 0) `CHK(d, pos_exp)
         `CHK(first_src, rt1)
         `CHK(second_src, rt2)
         wr(reg_reference_marker, 0);
         wr(reg_feedback_marker, 0);
         wr(reg_freeze_flags, 0);
         wr(reg_irq_status, 32'h1f);
         flag = '{0, 0};
         fz = '{0, 0};
         `CHK(irq, 0)
      end
      // Interrupt raised, masked, unmasked and cleared.
      wr(reg_irq_mask, 1);
      wr(reg_reference_source, 0);
      src[0] = 0;
      pulse('1);
      `CHK(irq, 1)
      wr(reg_irq_mask, 0);
      repeat (2) @(posedge clk_sys);
      `CHK(irq, 0)
      wr(reg_irq_mask, 1);
      repeat (2) @(posedge clk_sys);
      `CHK(irq, 1)
      wr(reg_irq_status, 1);
      repeat (2) @(posedge clk_sys);
      `CHK(irq, 0)
      // Each error code is loaded at its trip and read back after trip_81 is seen high.
      for (int e = 4; e >= 0; e--) begin
         @(posedge clk_sys);
         trip_code <= e;
         trip_go <= 1'b1;
         @(posedge clk_sys);
         trip_go <= 1'b0;
         do begin
            @(posedge clk_sys);
            #1;
         end while (trip_81 !== 1'b1);
         rd(reg_runtime_error, d); `CHK(d, e)
         repeat (8) @(posedge clk_sys);
      end
      tally_and_finish();
   end
endmodule // test_encoder_marker_freeze_capture_control
bind marker_freeze_control marker_freeze_checker u_marker_freeze_checker (.clk_sys(clk_sys), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .enc_pins(enc_pins), .reference_position(reference_position), .trip_81(trip_81),
   .trip_error_code(trip_error_code), .task_start(task_start),
   .first_freeze_position_source(first_freeze_position_source),
   .second_freeze_position_source(second_freeze_position_source), .irq(irq));
